// File: hdl/tfb_map.vh
// Purpose: constants for the timer flag, buffer timing and capture block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   included by tfb_top.v only
//
// What this block does
// - compare match on U/V/W sets match flag
// - input capture copies sub-counter, sets flag
// - pulse-width mode captures at IO_CONTROL_FIELD-chosen edge
// - flag clears only by read 1, write 0
// - buffer timing bits 7..3 read zero
// - E transfer on match E or counter clear
// - channels 3 and 4 E timing reads zero
// - D to B on match B or clear
// - C to A on match A or clear
// - timing regs for channels 0,3,4, PWM only
// - bit 3 adds ch2 B pin to ch1 B
// - bit 2 adds ch2 A pin to ch1 A
// - bit 1 adds ch1 B pin to ch2 B
// - bit 0 adds ch1 A pin to ch2 A
// - cascade reg bits 7..4 zero, cascade only
// - 8-bit sync clear select for ch3/ch4 counters
// - bit 7 clears on ch0 A flag set
// - bit 6 clears on ch0 B flag set
// - bits 5,4 clear on ch0 C, D flags
`ifndef TFB_MAP_VH
`define TFB_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TFB_OFF_FLAGS   8'h00
`define TFB_OFF_BTT0    8'h04
`define TFB_OFF_BTT3    8'h08
`define TFB_OFF_BTT4    8'h0c
`define TFB_OFF_CASC    8'h10
`define TFB_OFF_SYNC    8'h14
`define TFB_OFF_GRU     8'h18
`define TFB_OFF_GRV     8'h1c
`define TFB_OFF_GRW     8'h20
`define TFB_OFF_IOC     8'h24
// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define TFB_BIT_E       2
`define TFB_BIT_B       1
`define TFB_BIT_A       0
`define TFB_MASK_BTT0   8'h07
`define TFB_MASK_BTT34  8'h03
`define TFB_MASK_CASC   8'h0f
`define TFB_MASK_FLAGS  8'h07
`define TFB_IOC_EDGE    2
// ----------------------------------------
// Sub-channel modes (IO_CONTROL_FIELD bits 1..0)
// ----------------------------------------
`define TFB_MODE_CMP    2'h0
`define TFB_MODE_CAP    2'h1
`define TFB_MODE_PW     2'h2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TFB_RST8        8'h00
`define TFB_RST16       16'h0000
`define TFB_RESP_OKAY   2'h0
`define TFB_RESP_SLVERR 2'h2
`endif

// File: hdl/tfb_top.v
// Purpose: ch5 match flags, PWM buffer timing, cascade capture, sync clear
// Assumes: counters and compare sources run on aclk; pins are asynchronous
// Notes:   all outputs registered; AXI4-Lite slave for software
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "tfb_map.vh"

module tfb_top #(
   parameter AW = 8
) (
   // Clock and reset
   input  wire          aclk,
   input  wire          aresetn,
   // AXI4-Lite write address and data
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   // AXI4-Lite read
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // Channel 5 sub-counters and capture pins
   input  wire [15:0]   u_subcounter,
   input  wire [15:0]   v_subcounter,
   input  wire [15:0]   w_subcounter,
   input  wire [2:0]    ch5_capture_pin,
   output reg  [2:0]    ch5_match_flags,
   // Buffer transfer sources, index 0/1/2 = channel 0/3/4
   input  wire [2:0]    pwm_mode,
   input  wire [2:0]    cmp_a,
   input  wire [2:0]    cmp_b,
   input  wire          cmp_e,
   input  wire [2:0]    counter_clear,
   output reg  [2:0]    xfer_c_to_a,
   output reg  [2:0]    xfer_d_to_b,
   output reg           xfer_f_to_e,
   // Cascade capture pins and triggers
   input  wire          cascade_mode,
   input  wire          ch1_a_capture_pin,
   input  wire          ch1_b_capture_pin,
   input  wire          ch2_a_capture_pin,
   input  wire          ch2_b_capture_pin,
   output reg           ch1_a_capture,
   output reg           ch1_b_capture,
   output reg           ch2_a_capture,
   output reg           ch2_b_capture,
   // First-unit flags (bit 7 = ch0 A ... bit 0 = ch2 B) and clear
   input  wire [7:0]    first_unit_flags,
   output reg           sync_counter_clear
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Byte-lane merge of a 16-bit register
   function [15:0] merge16;
      input [15:0] old_v;
      input [31:0] wd;
      input [3:0]  st;
      begin
         merge16[7:0]  = st[0] ? wd[7:0]  : old_v[7:0];
         merge16[15:8] = st[1] ? wd[15:8] : old_v[15:8];
      end
   endfunction

   // Word-aligned register offset from a bus address
   function [7:0] word_addr;
      input [AW-1:0] a;
      begin
         word_addr = {a[7:2], 2'b00};
      end
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg  [6:0]  pin_s1_q;
   reg  [6:0]  pin_s2_q;
   reg  [6:0]  pin_s3_q;
   reg  [2:0]  flags_q;
   reg  [2:0]  flags_d;
   reg  [2:0]  armed_q;
   reg  [2:0]  armed_d;
   reg  [2:0]  eq_q;
   reg  [7:0]  btt0_q;
   reg  [7:0]  btt3_q;
   reg  [7:0]  btt4_q;
   reg  [7:0]  casc_q;
   reg  [7:0]  sync_q;
   reg  [7:0]  ufl_q;
   reg  [15:0] gr_u_q;
   reg  [15:0] gr_v_q;
   reg  [15:0] gr_w_q;
   reg  [8:0]  ioc_q;
   reg  [2:0]  cap_ev;
   reg  [2:0]  cmp_ev;
   reg  [2:0]  eq_now;
   reg  [2:0]  tta;
   reg  [2:0]  ttb;
   reg  [31:0] rd_d;
   reg  [1:0]  rresp_d;
   reg  [1:0]  md;
   integer     i;
   wire        wr_go;
   wire        rd_go;
   wire [7:0]  wa;
   wire [7:0]  ra;
   wire [6:0]  rise;
   wire [6:0]  fall;
   wire [7:0]  ufl_rise;
   wire [2:0]  clr_mask;

   // Register offsets and bus qualifiers
   assign wa    = word_addr(s_axi_awaddr);
   assign ra    = word_addr(s_axi_araddr);
   assign wr_go = s_axi_awready & s_axi_wready;
   assign rd_go = s_axi_arvalid & s_axi_arready;
   assign rise  = pin_s2_q & ~pin_s3_q;
   assign fall  = ~pin_s2_q & pin_s3_q;
   assign ufl_rise = first_unit_flags & ~ufl_q;
   // Flags a write may clear: read as 1, now written 0
   assign clr_mask = armed_q & ~s_axi_wdata[2:0];

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Two stages, third only for edge detection
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= 7'h00;
         pin_s2_q <= 7'h00;
         pin_s3_q <= 7'h00;
      end else begin
         pin_s1_q <= {ch2_b_capture_pin, ch2_a_capture_pin, ch1_b_capture_pin,
                      ch1_a_capture_pin, ch5_capture_pin};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // ----------------------------------------
   // Channel 5 events
   // ----------------------------------------
   // Compare and capture events per sub-channel (0=W,1=V,2=U)
   always @* begin
      eq_now[2] = (u_subcounter == gr_u_q);
      eq_now[1] = (v_subcounter == gr_v_q);
      eq_now[0] = (w_subcounter == gr_w_q);
      for (i = 0; i < 3; i = i + 1) begin
         md = ioc_q[3*i +: 2];
         cmp_ev[i] = (md == `TFB_MODE_CMP) & eq_now[i] & ~eq_q[i];
         if (md == `TFB_MODE_CAP)
            cap_ev[i] = rise[i];
         // Pulse-width edge picked by the I/O control field
         else if (md == `TFB_MODE_PW)
            cap_ev[i] = ioc_q[3*i+`TFB_IOC_EDGE] ? rise[i] : fall[i];
         else
            cap_ev[i] = 1'b0;
      end
   end

   // Flag set and read-then-write-zero clear
   always @* begin
      flags_d = flags_q;
      armed_d = armed_q;
      if (rd_go && ra == `TFB_OFF_FLAGS)
         armed_d = armed_q | flags_q;
      if (wr_go && wa == `TFB_OFF_FLAGS && s_axi_wstrb[0]) begin
         // Ones written leave the flag alone
         flags_d = flags_q & ~clr_mask;
         armed_d = armed_d & ~clr_mask;
      end
      // A set in the clearing cycle wins
      flags_d = flags_d | cmp_ev | cap_ev;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= 3'h0;
         armed_q <= 3'h0;
         eq_q    <= 3'h0;
      end else begin
         flags_q <= flags_d;
         armed_q <= armed_d;
         eq_q    <= eq_now;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         btt0_q <= `TFB_RST8;
         btt3_q <= `TFB_RST8;
         btt4_q <= `TFB_RST8;
         casc_q <= `TFB_RST8;
         sync_q <= `TFB_RST8;
         ioc_q  <= 9'h000;
      end else begin
         if (wr_go && s_axi_wstrb[0]) begin
            case (wa)
               `TFB_OFF_BTT0: btt0_q <= s_axi_wdata[7:0] & `TFB_MASK_BTT0;
               `TFB_OFF_BTT3: btt3_q <= s_axi_wdata[7:0] & `TFB_MASK_BTT34;
               `TFB_OFF_BTT4: btt4_q <= s_axi_wdata[7:0] & `TFB_MASK_BTT34;
               `TFB_OFF_CASC: casc_q <= s_axi_wdata[7:0] & `TFB_MASK_CASC;
               `TFB_OFF_SYNC: sync_q <= s_axi_wdata[7:0];
               `TFB_OFF_IOC:  ioc_q  <= s_axi_wdata[8:0];
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------
   // General registers U/V/W
   // ----------------------------------------
   // Capture beats a software write in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         gr_u_q <= `TFB_RST16;
         gr_v_q <= `TFB_RST16;
         gr_w_q <= `TFB_RST16;
      end else begin
         if (cap_ev[2])
            gr_u_q <= u_subcounter;
         else if (wr_go && wa == `TFB_OFF_GRU)
            gr_u_q <= merge16(gr_u_q, s_axi_wdata, s_axi_wstrb);
         if (cap_ev[1])
            gr_v_q <= v_subcounter;
         else if (wr_go && wa == `TFB_OFF_GRV)
            gr_v_q <= merge16(gr_v_q, s_axi_wdata, s_axi_wstrb);
         if (cap_ev[0])
            gr_w_q <= w_subcounter;
         else if (wr_go && wa == `TFB_OFF_GRW)
            gr_w_q <= merge16(gr_w_q, s_axi_wdata, s_axi_wstrb);
      end
   end

   // ----------------------------------------
   // Buffer transfer timing
   // ----------------------------------------
   // Timing bits per channel 0/3/4
   always @* begin
      tta = {btt4_q[`TFB_BIT_A], btt3_q[`TFB_BIT_A], btt0_q[`TFB_BIT_A]};
      ttb = {btt4_q[`TFB_BIT_B], btt3_q[`TFB_BIT_B], btt0_q[`TFB_BIT_B]};
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         xfer_c_to_a <= 3'h0;
         xfer_d_to_b <= 3'h0;
         xfer_f_to_e <= 1'b0;
      end else begin
         // Only in PWM mode
         xfer_c_to_a <= pwm_mode & ((tta & counter_clear) | (~tta & cmp_a));
         xfer_d_to_b <= pwm_mode & ((ttb & counter_clear) | (~ttb & cmp_b));
         xfer_f_to_e <= pwm_mode[0] & (btt0_q[`TFB_BIT_E] ? counter_clear[0]
                                                          : cmp_e);
      end
   end

   // ----------------------------------------
   // Cascade capture triggers
   // ----------------------------------------
   // Pin order in sync vector: 3=1A 4=1B 5=2A 6=2B
   always @(posedge aclk) begin
      if (!aresetn) begin
         ch1_a_capture <= 1'b0;
         ch1_b_capture <= 1'b0;
         ch2_a_capture <= 1'b0;
         ch2_b_capture <= 1'b0;
      end else begin
         ch1_b_capture <= rise[4] | (cascade_mode & casc_q[3] & rise[6]);
         ch1_a_capture <= rise[3] | (cascade_mode & casc_q[2] & rise[5]);
         ch2_b_capture <= rise[6] | (cascade_mode & casc_q[1] & rise[4]);
         ch2_a_capture <= rise[5] | (cascade_mode & casc_q[0] & rise[3]);
      end
   end

   // ----------------------------------------
   // Synchronous counter clear
   // ----------------------------------------
   // One pulse per flag rise, cycle after the rise
   always @(posedge aclk) begin
      if (!aresetn) begin
         ufl_q              <= 8'h00;
         sync_counter_clear <= 1'b0;
      end else begin
         ufl_q              <= first_unit_flags;
         sync_counter_clear <= |(ufl_rise & sync_q);
      end
   end

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   always @* begin
      rd_d    = 32'h0000_0000;
      rresp_d = `TFB_RESP_OKAY;
      case (ra)
         `TFB_OFF_FLAGS: rd_d[2:0]  = flags_q;
         `TFB_OFF_BTT0:  rd_d[7:0]  = btt0_q;
         `TFB_OFF_BTT3:  rd_d[7:0]  = btt3_q;
         `TFB_OFF_BTT4:  rd_d[7:0]  = btt4_q;
         `TFB_OFF_CASC:  rd_d[7:0]  = casc_q;
         `TFB_OFF_SYNC:  rd_d[7:0]  = sync_q;
         `TFB_OFF_GRU:   rd_d[15:0] = gr_u_q;
         `TFB_OFF_GRV:   rd_d[15:0] = gr_v_q;
         `TFB_OFF_GRW:   rd_d[15:0] = gr_w_q;
         `TFB_OFF_IOC:   rd_d[8:0]  = ioc_q;
         // Unmapped words read zero with an error
         default:        rresp_d    = `TFB_RESP_SLVERR;
      endcase
   end

   // ----------------------------------------
   // AXI4-Lite handshakes
   // ----------------------------------------
   // Write: take address and data together, then respond
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TFB_RESP_OKAY;
      end else begin
         s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                          & ~s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                          & ~s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            // Offsets beyond the last register answer an error
            s_axi_bresp  <= (wa > `TFB_OFF_IOC) ? `TFB_RESP_SLVERR : `TFB_RESP_OKAY;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read: one-cycle accept, data the edge after
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `TFB_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= rresp_d;
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Flags mirrored to a port
   always @(posedge aclk) begin
      if (!aresetn)
         ch5_match_flags <= 3'h0;
      else
         ch5_match_flags <= flags_d;
   end

endmodule // tfb_top

// File: tb/tfb_pin_src.sv
// Purpose: far-side source of capture pin levels
// Assumes: the bench requests each level
// Notes:   pins move off the clock grid, prompt or slow
`timescale 1ns/10ps
module tfb_pin_src (
   // Request
   input  wire logic       slow,
   input  wire logic [6:0] lvl,
   // Pins
   output logic      [6:0] pin
);
   // Pins follow requests after a skew unrelated to the clock
   initial pin = 7'h00;
   always @(lvl) pin <= #(slow ? 9.3 : 1.7) lvl;
endmodule // tfb_pin_src

// File: tb/tfb_top_chk.sv
// Purpose: port-level checker for tfb_top
// Assumes: one clock, synchronous active-low reset
// Notes:   attached by bind from the bench top
`timescale 1ns/10ps
module tfb_top_chk (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Block signals
   input wire logic [2:0]  ch5_match_flags,
   input wire logic [2:0]  pwm_mode,
   input wire logic [2:0]  cmp_a,
   input wire logic [2:0]  cmp_b,
   input wire logic        cmp_e,
   input wire logic [2:0]  counter_clear,
   input wire logic [2:0]  xfer_c_to_a,
   input wire logic [2:0]  xfer_d_to_b,
   input wire logic        xfer_f_to_e,
   input wire logic [7:0]  first_unit_flags,
   input wire logic        sync_counter_clear
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ---------------------------------
   // Steps
   // ---------------------------------
   sequence wr_hs;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence flag_fall;
      |($past(ch5_match_flags) & ~ch5_match_flags);
   endsequence
   // ---------------------------------
   // Properties
   // ---------------------------------
   chk_wr_answer: assert property (wr_hs |=> s_axi_bvalid)
      else $error("write answer late");
   chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write ready stands too long");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   chk_flag_clear: assert property (flag_fall |-> $past(s_axi_awvalid) && $past(s_axi_awready))
      else $error("flag cleared without a write");
   chk_xfer_a: assert property (|xfer_c_to_a |->
      (xfer_c_to_a & ~($past(pwm_mode) & ($past(cmp_a) | $past(counter_clear)))) == 3'h0)
      else $error("transfer to A without cause");
   chk_xfer_b: assert property (|xfer_d_to_b |->
      (xfer_d_to_b & ~($past(pwm_mode) & ($past(cmp_b) | $past(counter_clear)))) == 3'h0)
      else $error("transfer to B without cause");
   chk_xfer_e: assert property (xfer_f_to_e |->
      $past(pwm_mode[0]) && ($past(cmp_e) || $past(counter_clear[0])))
      else $error("transfer to E without cause");
   chk_sync_cause: assert property (sync_counter_clear |->
      |($past(first_unit_flags) & ~$past(first_unit_flags, 2)))
      else $error("counter clear without a flag rise");
endmodule // tfb_top_chk

// File: tb/tfb_top_tb_top.sv
// Purpose: self-checking bench for tfb_top
// Assumes: bus master and stimulus on aclk, fixed seed
// Notes:   pins come from the far-side source model
`timescale 1ns/10ps
module tfb_top_tb_top;
   logic        aclk, aresetn, slow, cascade_mode, cmp_e, xfer_f_to_e, sync_counter_clear;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, first_unit_flags, sel;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb, s;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [15:0] sc [3];
   logic [15:0] v;
   logic [6:0]  lvl, pin, ex;
   logic [7:0]  bt [3];
   logic [2:0]  ch5_match_flags, pwm_mode, cmp_a, cmp_b, counter_clear, xfer_c_to_a, xfer_d_to_b;
   logic        ch1_a_capture, ch1_b_capture, ch2_a_capture, ch2_b_capture;
   int          num_errors, n_checks, i, k;
   wire  [2:0]  ch5_capture_pin   = pin[2:0];
   wire         ch1_a_capture_pin = pin[3];
   wire         ch1_b_capture_pin = pin[4];
   wire         ch2_a_capture_pin = pin[5];
   wire         ch2_b_capture_pin = pin[6];
   wire  [15:0] u_subcounter = sc[2], v_subcounter = sc[1], w_subcounter = sc[0];
   tfb_top uut (.*);
   tfb_pin_src u_src (.slow(slow), .lvl(lvl), .pin(pin));
   // ---------------------------------
   // Helpers
   // ---------------------------------
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic lost;
      num_errors++;
      wrap_up();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] val);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= val;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      for (n = 0; n < 64 && !s_axi_bvalid; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      if (n == 64) lost();
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      for (n = 0; n < 64 && !s_axi_rvalid; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n == 64) lost();
      @(posedge aclk);
   endtask
   // Collect capture pulses over a settling window
   task automatic watch(output logic [3:0] seen);
      seen = 4'h0;
      repeat (8) @(posedge aclk) #1 seen |= {ch2_b_capture, ch2_a_capture, ch1_b_capture,
         ch1_a_capture};
      @(posedge aclk);
   endtask
   task automatic pin_u(input logic val);
      lvl[2] <= val;
      repeat (8) @(posedge aclk);
   endtask
   task automatic clr_u;
      rd(8'h00);
      wr(8'h00, 32'h3);
   endtask
   function automatic logic [31:0] rmask(int n);
      return n == 1 ? 32'h07 : n < 4 ? 32'h03 : n == 4 ? 32'h0f : 32'hff;
   endfunction
   function automatic logic [6:0] exp_x(logic [2:0] p, a, b, c, logic e);
      logic [2:0] xa, xb;
      for (int j = 0; j < 3; j++) begin
         xa[j] = p[j] & (bt[j][0] ? c[j] : a[j]);
         xb[j] = p[j] & (bt[j][1] ? c[j] : b[j]);
      end
      return {p[0] & (bt[0][2] ? c[0] : e), xb, xa};
   endfunction
   // ---------------------------------
   // Clock and main sequence
   // ---------------------------------
   initial begin
      aclk = 1'h0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      {aresetn, slow, cascade_mode, cmp_e, pwm_mode, cmp_a, cmp_b, counter_clear} = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, first_unit_flags, s_axi_wdata, lvl} = 0;
      s_axi_wstrb = 4'hf;
      sc = '{16'hffff, 16'hffff, 16'hffff};
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      void'($urandom(32'hab3e60be));
      for (i = 0; i < 10; i++) begin
         rd(8'(4 * i));
         chk("reset value", d, 32'h0);
      end
      for (i = 1; i < 6; i++) begin
         wr(8'(4 * i), 32'hffffffff);
         rd(8'(4 * i));
         chk("masked readback", d, rmask(i));
      end
      wr(8'h40, 32'h0);
      chk("unmapped write", r, 32'h2);
      rd(8'h40);
      chk("unmapped read", {d[29:0], r}, 32'h2);
      // Compare match per sub-channel, then read-before-clear
      for (i = 0; i < 3; i++) begin
         v = 16'h0100 + 16'($urandom_range(255));
         wr(8'h20 - 8'(4 * i), {16'h0, v});
         sc[i] <= v;
         repeat (3) @(posedge aclk);
         chk("compare flag", ch5_match_flags[i], 32'h1);
      end
      wr(8'h00, 32'h0);
      chk("unread flags kept", ch5_match_flags, 32'h7);
      clr_u();
      chk("one keeps flag", ch5_match_flags, 32'h3);
      wr(8'h00, 32'h0);
      chk("flags cleared", ch5_match_flags, 32'h0);
      // Capture, then falling- and rising-edge pulse width on U
      wr(8'h24, 32'h40);
      v = 16'($urandom);
      sc[2] <= v;
      slow <= 1'h1;
      pin_u(1'h1);
      chk("capture flag", ch5_match_flags, 32'h4);
      rd(8'h18);
      chk("captured count", d, {16'h0, v});
      clr_u();
      wr(8'h24, 32'h80);
      sc[2] <= v + 16'h1;
      pin_u(1'h0);
      chk("width flag", ch5_match_flags, 32'h4);
      rd(8'h18);
      chk("width count", d, {16'h0, v + 16'h1});
      clr_u();
      pin_u(1'h1);
      chk("wrong edge", ch5_match_flags, 32'h0);
      wr(8'h24, 32'h180);
      sc[2] <= v + 16'h2;
      pin_u(1'h0);
      chk("rising mode fall", ch5_match_flags, 32'h0);
      pin_u(1'h1);
      chk("rising width flag", ch5_match_flags, 32'h4);
      rd(8'h18);
      chk("rising width count", d, {16'h0, v + 16'h2});
      // Buffer transfer timing under random sources
      for (i = 0; i < 3; i++) begin
         bt[i] = 8'($urandom) & 8'(rmask(i + 1));
         wr(8'h04 + 8'(4 * i), {24'h0, bt[i]});
      end
      ex = 7'h0;
      repeat (80) begin
         @(posedge aclk);
         {pwm_mode, cmp_a, cmp_b, counter_clear, cmp_e} <= 13'($urandom);
         #1 chk("transfer", {xfer_f_to_e, xfer_d_to_b, xfer_c_to_a}, ex);
         ex = exp_x(pwm_mode, cmp_a, cmp_b, counter_clear, cmp_e);
      end
      @(posedge aclk);
      // Cascade capture inclusion
      for (k = 0; k < 8; k++) begin
         sel = 8'($urandom);
         cascade_mode <= k[0];
         slow <= k[1];
         wr(8'h10, {24'h0, sel});
         lvl[6:5] <= 2'h3;
         watch(s);
         chk("ch2 pins", s, {2'h3, k[0] & sel[3], k[0] & sel[2]});
         lvl[6:5] <= 2'h0;
         watch(s);
         lvl[4:3] <= 2'h3;
         watch(s);
         chk("ch1 pins", s, {k[0] & sel[1], k[0] & sel[0], 2'h3});
         lvl[4:3] <= 2'h0;
         watch(s);
      end
      // Synchronous clear from each first-unit flag
      sel = 8'($urandom);
      wr(8'h14, {24'h0, sel});
      for (k = 0; k < 8; k++) begin
         @(posedge aclk);
         first_unit_flags <= 8'h1 << k;
         @(posedge aclk);
         #1 chk("sync clear", sync_counter_clear, sel[k]);
         @(posedge aclk);
         #1 chk("no repeat", sync_counter_clear, 32'h0);
         @(posedge aclk);
         first_unit_flags <= 8'h0;
      end
      wrap_up();
   end
endmodule // tfb_top_tb_top
bind tfb_top tfb_top_chk u_chk (.*);
